// ==== hdl/pss_select.sv ====
// Purpose: Loads a stored parameter set per frame, picked by two lines.
// Assumes: Lines, trigger and frame end are synchronous to clk_i.
// Notes:   The active word is the set of sequence parameters in use.

module pss_select #(
  parameter int W          = 32,
  parameter int SETTLE_CYC = pss_pkg::SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Register port.
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  output logic      [31:0]  reg_rdata_o,
  // Trigger source side.
  input  wire logic         input_line_one_i,
  input  wire logic         input_line_two_i,
  input  wire logic         frame_trig_i,
  input  wire logic         frame_done_i,
  // Acquisition side.
  output logic      [W-1:0] active_param_o,
  output logic      [1:0]   current_set_o,
  output logic              waiting_o,
  output logic              acq_busy_o
);

  typedef struct packed {
    pss_pkg::pss_state_t st;
    logic                sequencer_on;
    logic [1:0]          set_advance_policy;
    logic [2:0]          stored_set_count;
    logic                addr_bit_pick;
    logic [1:0]          addr_bit_line;
    logic [1:0]          line_inv;
    logic [1:0]          slot_index;
    logic [W-1:0]        active;
    logic [W-1:0]        backup;
    logic [1:0]          cur_set;
    logic                trig_prev;
    logic [1:0]          lines_prev;
    logic [3:0]          settle;
    logic [31:0]         rdata;
  } pss_state_vec_t;

  pss_state_vec_t s;
  pss_state_vec_t next_s;

  logic         mem_wr;
  logic         mem_rd;
  logic [1:0]   mem_rd_addr;
  logic [W-1:0] mem_rd_data;

  logic [1:0]   lines;
  logic [1:0]   line_val;
  logic         bit0;
  logic         bit1;
  logic [1:0]   pin_addr;
  logic [1:0]   set_addr;
  logic         line_moved;
  logic         waiting;
  logic         trig_edge;
  logic         run_ok;
  logic         eff_pick;
  logic [2:0]   cnt_req;
  logic [31:0]  status;

  // Stored sets live in their own little memory.
  pss_set_mem #(
    .W     (W),
    .DEPTH (pss_pkg::MAX_SETS),
    .AW    (2)
  ) u_mem (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_en_i   (mem_wr),
    .wr_addr_i (s.slot_index),
    .wr_data_i (s.active),
    .rd_en_i   (mem_rd),
    .rd_addr_i (mem_rd_addr),
    .rd_data_o (mem_rd_data)
  );

  // Line levels to address bits, each through its own invert.
  assign lines    = {input_line_two_i, input_line_one_i};
  assign line_val = lines ^ s.line_inv;
  assign bit0     = line_val[s.addr_bit_line[0]];
  assign bit1     = line_val[s.addr_bit_line[1]];

  // Address width follows the set count; an address past the last
  // set is clipped to it so no unfilled slot can be reached.
  always_comb begin
    pin_addr = 2'h0;
    set_addr = 2'h0;
    if (s.stored_set_count > pss_pkg::SET_COUNT_TWO) begin
      pin_addr = {bit1, bit0};
    end else if (s.stored_set_count == pss_pkg::SET_COUNT_TWO) begin
      pin_addr = {1'b0, bit0};
    end
    set_addr = pin_addr;
    if ({1'b0, pin_addr} >= s.stored_set_count) begin
      set_addr = 2'(s.stored_set_count - 3'h1);
    end
  end

  // A moving line opens a quiet window in which triggers are lost.
  assign line_moved = (lines != s.lines_prev);
  assign waiting    = (s.st == pss_pkg::ST_WAIT) && !line_moved &&
                      (s.settle == 4'h0);
  assign trig_edge  = frame_trig_i && !s.trig_prev;
  assign run_ok     = s.sequencer_on &&
                      (s.set_advance_policy ==
                       pss_pkg::PIN_CHOSEN_ADVANCE);

  // Count two forces bit 0 as the configured bit.
  assign eff_pick = (s.stored_set_count > pss_pkg::SET_COUNT_TWO) ?
                    s.addr_bit_pick : 1'b0;

  // Requested count, limited into the legal range.
  always_comb begin
    cnt_req = reg_wdata_i[2:0];
    if (reg_wdata_i > 32'(pss_pkg::SET_COUNT_MAX)) begin
      cnt_req = pss_pkg::SET_COUNT_MAX;
    end else if (reg_wdata_i == 32'h0) begin
      cnt_req = pss_pkg::SET_COUNT_MIN;
    end
  end

  // Save strobe goes straight to the memory write port.
  assign mem_wr = reg_wr_i && (reg_addr_i == pss_pkg::OFS_SAVE) &&
                  reg_wdata_i[0];

  // A read of the addressed slot is issued on an accepted trigger.
  assign mem_rd      = waiting && trig_edge && run_ok;
  assign mem_rd_addr = set_addr;

  // Status word seen by software.
  always_comb begin
    status = 32'h0;
    status[pss_pkg::STAT_WAIT_BIT] = waiting;
    status[pss_pkg::STAT_BUSY_BIT] = (s.st == pss_pkg::ST_LOAD) ||
                                     (s.st == pss_pkg::ST_FRAME);
    status[pss_pkg::STAT_SET_LSB +: 2] = s.cur_set;
  end

  // Next state: register writes, read data and the sequencer.
  always_comb begin
    next_s           = s;
    next_s.trig_prev = frame_trig_i;
    next_s.lines_prev = lines;
    if (line_moved) begin
      next_s.settle = 4'(SETTLE_CYC);
    end else if (s.settle != 4'h0) begin
      next_s.settle = s.settle - 4'h1;
    end

    // Register writes; setup is assumed changed only while off.
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        pss_pkg::OFS_CTRL: begin
          next_s.sequencer_on = reg_wdata_i[pss_pkg::CTRL_ON_BIT];
          next_s.set_advance_policy =
            reg_wdata_i[pss_pkg::CTRL_POL_LSB +: 2];
        end
        pss_pkg::OFS_SET_COUNT: begin
          next_s.stored_set_count = cnt_req;
          if (cnt_req <= pss_pkg::SET_COUNT_TWO) begin
            next_s.addr_bit_pick = 1'b0;
          end
        end
        pss_pkg::OFS_BIT_PICK: begin
          next_s.addr_bit_pick = reg_wdata_i[0];
        end
        pss_pkg::OFS_BIT_LINE: begin
          next_s.addr_bit_line[eff_pick] = reg_wdata_i[0];
        end
        pss_pkg::OFS_LINE_INV: begin
          next_s.line_inv = reg_wdata_i[1:0];
        end
        pss_pkg::OFS_SLOT: begin
          next_s.slot_index = reg_wdata_i[1:0];
        end
        pss_pkg::OFS_ACTIVE: begin
          if (s.st == pss_pkg::ST_OFF) begin
            next_s.active = reg_wdata_i[W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Read data stand only in the cycle after the strobe.
    next_s.rdata = 32'h0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        pss_pkg::OFS_CTRL: begin
          next_s.rdata[pss_pkg::CTRL_ON_BIT] = s.sequencer_on;
          next_s.rdata[pss_pkg::CTRL_POL_LSB +: 2] =
            s.set_advance_policy;
        end
        pss_pkg::OFS_SET_COUNT: begin
          next_s.rdata[2:0] = s.stored_set_count;
        end
        pss_pkg::OFS_BIT_PICK: begin
          next_s.rdata[0] = eff_pick;
        end
        pss_pkg::OFS_BIT_LINE: begin
          next_s.rdata[0] = s.addr_bit_line[eff_pick];
        end
        pss_pkg::OFS_LINE_INV: begin
          next_s.rdata[1:0] = s.line_inv;
        end
        pss_pkg::OFS_SLOT: begin
          next_s.rdata[1:0] = s.slot_index;
        end
        pss_pkg::OFS_ACTIVE: begin
          next_s.rdata[W-1:0] = s.active;
        end
        pss_pkg::OFS_STATUS: begin
          next_s.rdata = status;
        end
        default: begin
        end
      endcase
    end

    // Sequencer. Switching off mid frame lets the frame finish first.
    unique case (s.st)
      pss_pkg::ST_OFF: begin
        if (run_ok) begin
          next_s.backup = s.active;
          next_s.st     = pss_pkg::ST_WAIT;
        end
      end
      pss_pkg::ST_WAIT: begin
        if (!run_ok) begin
          next_s.active = s.backup;
          next_s.st     = pss_pkg::ST_OFF;
        end else if (mem_rd) begin
          next_s.cur_set = set_addr;
          next_s.st      = pss_pkg::ST_LOAD;
        end
      end
      pss_pkg::ST_LOAD: begin
        next_s.active = mem_rd_data;
        next_s.st     = pss_pkg::ST_FRAME;
      end
      pss_pkg::ST_FRAME: begin
        if (frame_done_i) begin
          if (run_ok) begin
            next_s.st = pss_pkg::ST_WAIT;
          end else begin
            next_s.active = s.backup;
            next_s.st     = pss_pkg::ST_OFF;
          end
        end
      end
    endcase
  end

  // State register; the reset values are all constants.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s                    <= '0;
      s.st                 <= pss_pkg::ST_OFF;
      s.set_advance_policy <= pss_pkg::POLICY_RST;
      s.stored_set_count   <= pss_pkg::SET_COUNT_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs.
  assign reg_rdata_o    = s.rdata;
  assign active_param_o = s.active;
  assign current_set_o  = s.cur_set;
  assign waiting_o      = waiting;
  assign acq_busy_o     = status[pss_pkg::STAT_BUSY_BIT];

endmodule : pss_select

// ==== hdl/pss_pkg.sv ====
// Purpose: Shared constants and types of the pin addressed set selector.
// Assumes: A 250 MHz clock and a word wide register port.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package pss_pkg;

  // Clock and the quiet time after an address line moves.
  localparam int CLK_NS     = 4;
  localparam int SETTLE_NS  = 16;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // Stored set limits.
  localparam int         MAX_SETS      = 4;
  localparam logic [2:0] SET_COUNT_MAX = 3'h4;
  localparam logic [2:0] SET_COUNT_MIN = 3'h1;
  localparam logic [2:0] SET_COUNT_RST = 3'h2;
  localparam logic [2:0] SET_COUNT_TWO = 3'h2;

  // Register offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SET_COUNT = 8'h04;
  localparam logic [7:0] OFS_BIT_PICK  = 8'h08;
  localparam logic [7:0] OFS_BIT_LINE  = 8'h0C;
  localparam logic [7:0] OFS_LINE_INV  = 8'h10;
  localparam logic [7:0] OFS_SLOT      = 8'h14;
  localparam logic [7:0] OFS_SAVE      = 8'h18;
  localparam logic [7:0] OFS_ACTIVE    = 8'h1C;
  localparam logic [7:0] OFS_STATUS    = 8'h20;

  // Field positions.
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_POL_LSB  = 1;
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SET_LSB  = 2;

  // Advance policies; only the pin chosen one is served here.
  localparam logic [1:0] POLICY_RST         = 2'h0;
  localparam logic [1:0] PIN_CHOSEN_ADVANCE = 2'h1;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT,
    ST_LOAD,
    ST_FRAME
  } pss_state_t;

endpackage : pss_pkg

// ==== hdl/pss_set_mem.sv ====
// Purpose: Small store of parameter sets with a registered read port.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data stand one cycle after the read enable.
module pss_set_mem #(
  parameter int W     = 32,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Write port.
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i,
  // Read port.
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [W-1:0]  rd_data_o
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rd;
  } pss_mem_state_t;

  pss_mem_state_t s;
  pss_mem_state_t next_s;

  // A save overwrites the whole slot; a read takes the old word.
  always_comb begin
    next_s = s;
    if (wr_en_i) begin
      next_s.mem[wr_addr_i] = wr_data_i;
    end
    if (rd_en_i) begin
      next_s.rd = s.mem[rd_addr_i];
    end
  end

  // State register.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd;

endmodule : pss_set_mem

// ==== verif/pss_trig_src.sv ====
// Purpose: Trigger source model driving address lines and frame strobes.
// Assumes: Lines are plain levels that this source always drives.
// Notes:   HOLD cycles stand for the one microsecond quiet time.
module pss_trig_src #(
  parameter int HOLD = 250
) (
  // Clock.
  input  wire logic clk_i,
  // Lines and frame strobes.
  output logic      line_one_o,
  output logic      line_two_o,
  output logic      trig_o,
  output logic      done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Everything starts low so the first trigger is a clean rise.
  initial {line_one_o, line_two_o, trig_o, done_o} = 4'h0;

  // Lines settle pre cycles ahead of the rise and hold well after it.
  // A pre of zero moves lines and trigger together, which must be ignored.
  task automatic go(input logic l1, input logic l2, input int pre);
    line_one_o <= l1;
    line_two_o <= l2;
    repeat (pre) @(posedge clk_i);
    trig_o <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    trig_o <= 1'b0;
    @(posedge clk_i);
  endtask : go

  // One cycle end of frame pulse.
  task automatic frame_end();
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    @(posedge clk_i);
  endtask : frame_end
endmodule : pss_trig_src

// ==== verif/pss_select_assertions.sv ====
// Purpose: Port level checks of the pin addressed set selector.
// Assumes: Software keeps the pin chosen policy whenever the sequencer runs.
// Notes:   Bound to every instance of the selector.
module pss_select_assertions #(
  parameter int W = 32
) (
  input wire logic         clk_i,
  input wire logic         reset_i,
  input wire logic [7:0]   reg_addr_i,
  input wire logic [31:0]  reg_wdata_i,
  input wire logic         reg_wr_i,
  input wire logic         reg_rd_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire logic         input_line_one_i,
  input wire logic         input_line_two_i,
  input wire logic         frame_trig_i,
  input wire logic         frame_done_i,
  input wire logic [W-1:0] active_param_o,
  input wire logic [1:0]   current_set_o,
  input wire logic         waiting_o,
  input wire logic         acq_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Setup and trigger acceptance.
  property p_set_count;
    reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[2:0] > 3'h4 ##2
    reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o[2:0] == 3'h4;
  endproperty
  a_set_count: assert property (p_set_count)
    else $error("set count not limited to four");
  property p_trig_busy;
    waiting_o && frame_trig_i && !$past(frame_trig_i) |=> acq_busy_o;
  endproperty
  a_trig_busy: assert property (p_trig_busy)
    else $error("accepted trigger did not start a load");
  property p_rose_cause;
    $rose(acq_busy_o) |->
      $past(waiting_o) && $past(frame_trig_i) && !$past(frame_trig_i, 2);
  endproperty
  a_rose_cause: assert property (p_rose_cause)
    else $error("load started without an accepted trigger");
  property p_set_hold;
    acq_busy_o && $past(acq_busy_o) |-> $stable(current_set_o);
  endproperty
  a_set_hold: assert property (p_set_hold)
    else $error("current set moved inside a frame");

  // Waiting status and frame end.
  property p_excl;
    waiting_o |-> !acq_busy_o;
  endproperty
  a_excl: assert property (p_excl)
    else $error("waiting while busy");
  property p_quiet;
    $changed(input_line_one_i) || $changed(input_line_two_i)
      |-> !waiting_o [*2];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("waiting while an address line moves");
  property p_drop;
    $past(acq_busy_o) && acq_busy_o && frame_done_i |=> !acq_busy_o;
  endproperty
  a_drop: assert property (p_drop)
    else $error("busy held after frame end");
  property p_active_cause;
    $changed(active_param_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2)
      || $past(acq_busy_o) || $past(acq_busy_o, 2);
  endproperty
  a_active_cause: assert property (p_active_cause)
    else $error("active word changed without a cause");

  // Main scenarios reached.
  c_load: cover property ($rose(acq_busy_o));
  c_refuse: cover property ($changed(input_line_one_i) && $rose(frame_trig_i));
  c_clip: cover property (p_set_count);
endmodule : pss_select_assertions

bind pss_select pss_select_assertions #(.W(W)) u_chk (.clk_i, .reset_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .input_line_one_i, .input_line_two_i, .frame_trig_i, .frame_done_i,
  .active_param_o, .current_set_o, .waiting_o, .acq_busy_o);

// ==== verif/tb.sv ====
// Purpose: Self checking bench of the pin addressed set selector.
// Assumes: Stored words 0xA0 plus index, baseline active word 0x55.
// Notes:   The register port is a plain one cycle strobe bus.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, reset_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, active_param_o;
  logic [1:0]  current_set_o;
  logic        waiting_o, acq_busy_o, line_one, line_two, trig, done;
  int          bad_count, comparisons, cyc;

  pss_select u_dut (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .input_line_one_i(line_one),
    .input_line_two_i(line_two), .frame_trig_i(trig), .frame_done_i(done),
    .active_param_o, .current_set_o, .waiting_o, .acq_busy_o);
  pss_trig_src u_src (.clk_i, .line_one_o(line_one), .line_two_o(line_two),
    .trig_o(trig), .done_o(done));

  // A 4 ns clock.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // A run takes some 3900 cycles, so a hang is cut well beyond that.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Bus cycles leave a free edge behind so strobes never merge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask : rd

  // One accepted frame: expected set s and its stored word.
  task automatic frame(input logic l1, input logic l2, input logic [1:0] s);
    u_src.go(l1, l2, 250);
    #1 chk(32'(current_set_o), 32'(s));
    chk(active_param_o, 32'hA0 + 32'(s));
    chk(32'(acq_busy_o), 32'h1);
    @(posedge clk_i);
    rd(8'h20, 32'h2 | (32'(s) << 2));
    u_src.frame_end();
    #1 chk(32'(acq_busy_o), 32'h0);
    chk(32'(waiting_o), 32'h1);
    @(posedge clk_i);
  endtask : frame

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask : tdone

  // Main sequence.
  initial begin
    {reset_i, reg_wr_i, reg_rd_i} = 3'h4;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h04, 32'h2);
    for (int a = 0; a < 9; a++) if (a != 1) rd(8'(a * 4), 32'h0);
    rd(8'h40, 32'h0);
    tdone("reset");
    wr(8'h04, 32'h7);
    rd(8'h04, 32'h4);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1);
    tdone("clip");
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h1);
    rd(8'h08, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h1C, 32'hA0 + 32'(i));
      wr(8'h14, 32'(i));
      wr(8'h18, 32'h1);
    end
    wr(8'h1C, 32'h55);
    wr(8'h00, 32'h3);
    for (int i = 0; i < 4; i++) frame(i[0], i[1], 2'(i));
    tdone("sets");
    u_src.go(1'b0, 1'b1, 0);
    #1 chk(32'(acq_busy_o), 32'h0);
    @(posedge clk_i);
    wr(8'h00, 32'h2);
    rd(8'h1C, 32'h55);
    tdone("refuse");
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h3);
    frame(1'b0, 1'b0, 2'h1);
    wr(8'h00, 32'h2);
    tdone("invert");
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h3);
    frame(1'b1, 1'b1, 2'h1);
    frame(1'b1, 1'b0, 2'h0);
    wr(8'h00, 32'h2);
    rd(8'h1C, 32'h55);
    tdone("pair");
    close_out();
  end
endmodule : tb
